// ==== src/asc_defines.svh ====
// Function
// R1 - read: host holds chip select and output enable low
// R2 - write strobe stays high throughout a read
// R3 - memory keeps old byte at least 2 ns after address change
// R4 - memory gives valid data within 3 ns of output enable low
// R5 - memory floats bus within 3 ns of output enable high
// R6 - memory floats bus within 3 ns of chip select high
// R7 - memory may drive 0 ns after output enable low; host off bus
// R8 - address valid no later than chip select falling
// R9 - chip select or write strobe high while address changes
// R10 - write ends on first rise of chip select or write strobe
// R11 - write address stable at least 8 ns before write end
// R12 - write data valid at least 5 ns before write end
// R13 - address may change 0 ns after write end
// R14 - memory floats bus within 6 ns of write strobe falling
// R15 - memory drives again no sooner than 1 ns after write end
// R16 - chip select high before retention; wait read cycle after recovery
// R17 - read timing counted from last valid address
// R18 - memory floats outputs when deselected, disabled or writing
// R19 - memory stores byte on closing strobe edge
// R20 - memory holds 131072 bytes, 17-bit address
// R21 - host converts every delay to clock cycles, rounding safe; code converts five of the delays, rounding up
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_CLK_PERIOD_NS 8
`define ASC_ADDR_W 17
`define ASC_DATA_W 8
`define ASC_READ_CYCLE_MIN_NS 10
`define ASC_OE_ACCESS_NS 3
`define ASC_ADDR_ACCESS_NS 10
`define ASC_OUTPUT_DISABLE_FLOAT_NS 3
`define ASC_SELECT_DISABLE_FLOAT_NS 3
`define ASC_ADDRESS_TO_WRITE_END_NS 8
`define ASC_DATA_TO_WRITE_END_NS 5
`define ASC_WRITE_PULSE_NS 7
`define ASC_WRITE_TO_FLOAT_NS 6
`define ASC_DRIVE_AFTER_WRITE_END_NS 1
`define ASC_CEIL_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
// read: data valid after the address access time, rounded up to cycles, plus
// three cycles for the three-stage input synchroniser agreement
`define ASC_RD_CYC (`ASC_CEIL_CYC(`ASC_ADDR_ACCESS_NS) + 3)
`define ASC_WR_CYC `ASC_CEIL_CYC(`ASC_ADDRESS_TO_WRITE_END_NS)
`define ASC_FLOAT_CYC `ASC_CEIL_CYC(`ASC_WRITE_TO_FLOAT_NS)
`define ASC_REL_CYC `ASC_CEIL_CYC(`ASC_OUTPUT_DISABLE_FLOAT_NS)
`define ASC_RETAIN_CYC `ASC_CEIL_CYC(`ASC_READ_CYCLE_MIN_NS)
`endif

// ==== src/asc_pkg.sv ====
package asc_pkg;
  typedef struct packed {
    logic write;
    logic [16:0] addr;
    logic [7:0] wdata;
  } asc_req_t;
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [16:0] addr;
  } asc_pins_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR, ST_REL, ST_RETAIN, ST_RECOVER
  } asc_state_t;
endpackage : asc_pkg

// ==== src/asc_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.svh"
module asc_ctrl (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_req_valid,
  input wire asc_pkg::asc_req_t i_req,
  output logic o_req_ready,
  output logic o_rdata_valid,
  output logic [7:0] o_rdata,
  input wire logic i_retain,
  output logic o_retained,
  output asc_pkg::asc_pins_t o_pins,
  input wire logic [7:0] i_data_bus,
  output logic [7:0] o_data_bus,
  output logic o_data_bus_oe
);
  import asc_pkg::*;

  localparam logic [3:0] RD_CYC = 4'(`ASC_RD_CYC); // R21
  localparam logic [3:0] WR_CYC = 4'(`ASC_WR_CYC); // R11 R12
  localparam logic [3:0] FLOAT_CYC = 4'(`ASC_FLOAT_CYC); // R14
  localparam logic [3:0] REL_CYC = 4'(`ASC_REL_CYC); // R5 R6
  localparam logic [3:0] RET_CYC = 4'(`ASC_RETAIN_CYC); // R16

  asc_state_t state_q;
  logic [3:0] cnt_q;
  asc_pins_t pins_q;
  logic [7:0] wdata_q;
  logic oe_q;
  logic [7:0] s1_q, s2_q, s3_q;
  logic bus_agree;

  // ----------------------------------------
  // counter end test
  // ----------------------------------------
  function automatic logic last_cyc(input logic [3:0] cnt);
    return cnt == 4'h1;
  endfunction : last_cyc

  // ----------------------------------------
  // input synchroniser for the data bus
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    s1_q <= i_data_bus;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // change counts once second and third stage agree
  assign bus_agree = (s2_q == s3_q);

  // ----------------------------------------
  // output wiring
  // ----------------------------------------
  assign o_req_ready = (state_q == ST_IDLE) && !i_retain;
  assign o_pins = pins_q;
  assign o_data_bus = wdata_q;
  assign o_data_bus_oe = oe_q;
  assign o_retained = (state_q == ST_RETAIN);

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      pins_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 17'h0};
      wdata_q <= 8'h00;
      oe_q <= 1'b0;
      o_rdata_valid <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_rdata_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_retain) begin
            pins_q.cs_n <= 1'b1; // R16
            state_q <= ST_RETAIN;
          end else if (i_req_valid) begin
            // address set with strobes high; write select falls next edge, read select falls this edge
            pins_q.addr <= i_req.addr; // R8 R9 R17
            wdata_q <= i_req.wdata;
            if (i_req.write) begin
              state_q <= ST_WR_SETUP;
            end else begin
              pins_q.cs_n <= 1'b0; // R1
              pins_q.oe_n <= 1'b0; // R1 R7
              pins_q.we_n <= 1'b1; // R2
              cnt_q <= RD_CYC;
              state_q <= ST_RD;
            end
          end
        end
        ST_RD: begin
          // a byte still settling in the synchroniser holds the read open
          if (last_cyc(cnt_q) && bus_agree) begin
            o_rdata <= s3_q; // R4
            o_rdata_valid <= 1'b1;
            pins_q.cs_n <= 1'b1;
            pins_q.oe_n <= 1'b1;
            cnt_q <= REL_CYC;
            state_q <= ST_REL;
          end else if (!last_cyc(cnt_q)) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_WR_SETUP: begin
          pins_q.cs_n <= 1'b0;
          pins_q.we_n <= 1'b0;
          cnt_q <= FLOAT_CYC;
          state_q <= ST_WR;
        end
        ST_WR: begin
          // drive only once the memory has floated its outputs
          if (last_cyc(cnt_q) && !oe_q) begin
            oe_q <= 1'b1; // R14
            cnt_q <= WR_CYC;
          end else if (last_cyc(cnt_q)) begin
            pins_q.we_n <= 1'b1; // R10
            pins_q.cs_n <= 1'b1;
            cnt_q <= REL_CYC;
            state_q <= ST_REL;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_REL: begin
          oe_q <= 1'b0; // R13 R15
          if (last_cyc(cnt_q)) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_RETAIN: begin
          if (!i_retain) begin
            cnt_q <= RET_CYC;
            state_q <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (last_cyc(cnt_q)) begin
            state_q <= ST_IDLE; // R16
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence wr_open_s;
    !pins_q.we_n && !pins_q.cs_n;
  endsequence

  read_we_high_a: assert property (@(posedge i_clock) disable iff (i_srst) // R2
    !pins_q.oe_n |-> pins_q.we_n) else $error("write strobe low during read");
  read_strobes_a: assert property (@(posedge i_clock) disable iff (i_srst) // R1
    (state_q == ST_RD) |-> (!pins_q.cs_n && !pins_q.oe_n)) else $error("read strobes off");
  no_contention_a: assert property (@(posedge i_clock) disable iff (i_srst) // R7
    oe_q |-> pins_q.oe_n) else $error("host drives while output enabled");
  addr_stable_a: assert property (@(posedge i_clock) disable iff (i_srst) // R9
    $changed(pins_q.addr) |-> ($past(pins_q.cs_n) || $past(pins_q.we_n)))
    else $error("address moved during write");
  write_data_a: assert property (@(posedge i_clock) disable iff (i_srst) // R12
    wr_open_s ##1 pins_q.we_n |-> $past(oe_q, 1)) else $error("write closed without data");
  write_length_a: assert property (@(posedge i_clock) disable iff (i_srst) // R11
    $fell(pins_q.we_n) |-> !pins_q.we_n [*2]) else $error("write pulse short");
  retain_cs_a: assert property (@(posedge i_clock) disable iff (i_srst) // R16
    (state_q == ST_RETAIN) |-> pins_q.cs_n) else $error("select low in retention");
  read_done_a: assert property (@(posedge i_clock) disable iff (i_srst) // R4
    $fell(pins_q.oe_n) |-> ##[1:8] o_rdata_valid) else $error("read answer late");

  // ----------------------------------------
  // write checks
  // ----------------------------------------
  sequence wr_close_s;
    wr_open_s ##1 (pins_q.we_n && pins_q.cs_n);
  endsequence

  wr_addr_hold_a: assert property (@(posedge i_clock) disable iff (i_srst) // R11
    wr_open_s |-> $stable(pins_q.addr)) else $error("address moved in write pulse");
  wr_close_both_a: assert property (@(posedge i_clock) disable iff (i_srst) // R10
    $rose(pins_q.we_n) |-> pins_q.cs_n) else $error("write closed by one strobe");
  wr_data_hold_a: assert property (@(posedge i_clock) disable iff (i_srst) // R12
    wr_close_s |-> oe_q) else $error("write data dropped at close");
  float_wait_a: assert property (@(posedge i_clock) disable iff (i_srst) // R14
    $fell(pins_q.we_n) |-> !oe_q) else $error("host drove before memory floated");

  // ----------------------------------------
  // read and idle checks
  // ----------------------------------------
  rd_addr_hold_a: assert property (@(posedge i_clock) disable iff (i_srst) // R17
    (state_q == ST_RD) ##1 (state_q == ST_RD) |-> $stable(pins_q.addr))
    else $error("address moved in read");
  rd_pulse_a: assert property (@(posedge i_clock) disable iff (i_srst) // R4
    o_rdata_valid |=> !o_rdata_valid) else $error("read pulse too long");
  idle_quiet_a: assert property (@(posedge i_clock) disable iff (i_srst) // R9
    (state_q == ST_IDLE) |-> (pins_q.cs_n && pins_q.we_n && !oe_q))
    else $error("strobes active in idle");

  // ----------------------------------------
  // retention checks
  // ----------------------------------------
  retain_entry_a: assert property (@(posedge i_clock) disable iff (i_srst) // R16
    $rose(o_retained) |-> $past(pins_q.cs_n)) else $error("select low entering retention");
  recover_wait_a: assert property (@(posedge i_clock) disable iff (i_srst) // R16
    $fell(o_retained) |-> !o_req_ready [*2]) else $error("access resumed early");
endmodule : asc_ctrl
`default_nettype wire

// ==== tb/asc_sram_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module asc_sram_model #(
  parameter int DLY = 3
) (
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [16:0] i_addr,
  input wire logic i_host_oe,
  input wire logic [7:0] i_host_data,
  output logic [7:0] o_bus
);
  logic [7:0] mem [0:131071];
  logic drive;
  logic wr_open = 1'b0;
  // ----------------------------------------
  // output drive, delayed as a slow part
  // ----------------------------------------
  assign #(DLY) drive = !i_cs_n && !i_oe_n && i_we_n;
  // undriven bus shows the inverse, not the old byte
  assign o_bus = i_host_oe ? i_host_data : (drive ? mem[i_addr] : ~mem[i_addr]);
  // ----------------------------------------
  // write commit on the first closing strobe
  // ----------------------------------------
  // both strobes may rise in one step; commit when the open write closes
  always @(i_cs_n or i_we_n) begin
    if (wr_open && (i_cs_n || i_we_n)) begin
      mem[i_addr] <= i_host_data;
    end
    wr_open = !i_cs_n && !i_we_n;
  end
endmodule : asc_sram_model
`default_nettype wire

// ==== tb/test_async_sram_byte_interface.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_async_sram_byte_interface;
  import asc_pkg::*;
  logic clk = 0, srst = 1, valid = 0, retain = 0, rv, ready, ret, oe;
  asc_req_t req = '0;
  asc_pins_t pins;
  logic [7:0] rdata, dout, dbus;
  int errors = 0, n_tests = 0;
  always #4 clk = ~clk;
  asc_ctrl i_dut(.i_clock(clk), .i_srst(srst), .i_req_valid(valid), .i_req(req),
    .o_req_ready(ready), .o_rdata_valid(rv), .o_rdata(rdata), .i_retain(retain),
    .o_retained(ret), .o_pins(pins), .i_data_bus(dbus), .o_data_bus(dout),
    .o_data_bus_oe(oe));
  asc_sram_model i_mem(.i_cs_n(pins.cs_n), .i_oe_n(pins.oe_n), .i_we_n(pins.we_n),
    .i_addr(pins.addr), .i_host_oe(oe), .i_host_data(dout), .o_bus(dbus));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task conclude;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wait_ready;
    int i;
    for (i = 0; i < 50 && ready !== 1'b1; i++) @(posedge clk) #1;
    if (i == 50) begin
      errors++;
      conclude();
    end
  endtask : wait_ready
  task issue(input logic w, input logic [16:0] a, input logic [7:0] d);
    wait_ready();
    valid = 1;
    req = '{write: w, addr: a, wdata: d};
    @(posedge clk) #1;
    valid = 0;
  endtask : issue
  task rd(input logic [16:0] a, input logic [7:0] exp);
    int i;
    issue(0, a, 8'h00);
    for (i = 0; i < 20 && rv !== 1'b1; i++) @(posedge clk) #1;
    if (i == 20) begin
      errors++;
      conclude();
    end
    chk(rdata, exp);
  endtask : rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_idle;
    chk({4'h0, pins.cs_n, pins.oe_n, pins.we_n, oe}, 8'h0e);
  endtask : t_idle
  task t_write_read;
    issue(1, 17'h00000, 8'h5a);
    issue(1, 17'h1ffff, 8'ha5);
    rd(17'h00000, 8'h5a);
    rd(17'h1ffff, 8'ha5);
    issue(1, 17'h00000, 8'h3c);
    rd(17'h00000, 8'h3c);
  endtask : t_write_read
  task t_retention;
    wait_ready();
    retain = 1;
    repeat (3) @(posedge clk) #1;
    chk({6'h00, ret, pins.cs_n}, 8'h03);
    chk({7'h00, ready}, 8'h00);
    retain = 0;
    rd(17'h1ffff, 8'ha5);
  endtask : t_retention
  initial begin
    repeat (2) @(posedge clk) #1;
    srst = 0;
    t_idle();
    t_write_read();
    t_retention();
    conclude();
  end
endmodule : test_async_sram_byte_interface
`default_nettype wire
